/* hdl/fcm_pkg.sv */
// Package of constants and register offsets for the flash command and map control block.
//
// Summary of operation
// - Enable code 101 takes effect on commit D5.
// - Disable code 010 takes effect on commit D5.
// - Disabled: ignore command writes, no toggle.
// - Reset loads command enable field with 010.
// - Disable rejects new writes, keeps sequence.
// - Window select 10 maps code upper half.
// - Window select 00 restores default mapping.
// - Commands reach flash only via data space.
// - With select 10, data and code decode to same flash cells.
// - RAM code map commits on key D4.
// - Boot ROM show overlays 1000 to 17FF, code to 1FFF in serial PROM mode.
// - Serial PROM mode forces boot ROM shown.
// - Standby bit written only from RAM code.
// - Flash access in standby raises reset, except during flash-vector interrupt ack.
// - Interrupt clears standby unless vector in RAM.
// - Serial PROM mode gates port inputs by bits.
// - MCU mode ignores port input control.
// - Decode unlock AA at 555, 55 at AAA.
// - A0 third write arms byte program.
// - 80, unlock, 30 erases addressed sector.
// - Command upper nibble 8 to F accepted.
// - Map control staged until commit D5.
// - Busy reads toggle bit 6 each read.
package fcm_pkg;
  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [7:0] FCM_OFS_MAP_CTRL = 8'h00;
  localparam logic [7:0] FCM_OFS_COMMIT = 8'h04;
  localparam logic [7:0] FCM_OFS_MONITOR = 8'h08;
  localparam logic [7:0] FCM_OFS_STANDBY = 8'h0C;
  localparam logic [7:0] FCM_OFS_PORT_CTRL = 8'h10;
  localparam logic [7:0] FCM_OFS_SYS_CFG3 = 8'h14;
  localparam logic [7:0] FCM_OFS_SYS_KEY = 8'h18;
  localparam logic [7:0] FCM_OFS_STATUS = 8'h1C;
  // Map control field positions.
  localparam int FCM_POS_WIN = 2;
  localparam int FCM_POS_BOOT = 4;
  localparam int FCM_POS_MODE = 5;
  // Values of fields and keys.
  localparam logic [2:0] FCM_MODE_ENABLE = 3'h5;
  localparam logic [2:0] FCM_MODE_DISABLE = 3'h2;
  localparam logic [1:0] FCM_WIN_DEFAULT = 2'h0;
  localparam logic [1:0] FCM_WIN_CODE = 2'h2;
  localparam logic [7:0] FCM_COMMIT_KEY = 8'hD5;
  localparam logic [7:0] FCM_SYS_KEY = 8'hD4;
  localparam logic [7:0] FCM_MAP_RESET = 8'h40;
  // Command bytes and addresses.
  localparam logic [7:0] FCM_CMD_UNLOCK1 = 8'hAA;
  localparam logic [7:0] FCM_CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] FCM_CMD_PROG = 8'hA0;
  localparam logic [7:0] FCM_CMD_ERASE = 8'h80;
  localparam logic [7:0] FCM_CMD_SECTOR = 8'h30;
  localparam logic [7:0] FCM_CMD_CHIP = 8'h10;
  localparam logic [7:0] FCM_CMD_ID = 8'h90;
  localparam logic [7:0] FCM_CMD_ID_EXIT = 8'hF0;
  localparam logic [7:0] FCM_CMD_SECURE = 8'hA5;
  localparam logic [7:0] FCM_SECURE_DATA = 8'h00;
  localparam logic [15:0] FCM_SECURE_ADDR = 16'hFF7F;
  localparam logic [11:0] FCM_ADDR_555 = 12'h555;
  localparam logic [11:0] FCM_ADDR_AAA = 12'hAAA;
  localparam logic [15:0] FCM_BOOT_LO = 16'h1000;
  localparam logic [15:0] FCM_BOOT_HI_DATA = 16'h17FF;
  localparam logic [15:0] FCM_BOOT_HI_CODE = 16'h1FFF;
  // Operation codes.
  localparam logic [2:0] FCM_OP_NONE = 3'h0;
  localparam logic [2:0] FCM_OP_PROG = 3'h1;
  localparam logic [2:0] FCM_OP_SECTOR = 3'h2;
  localparam logic [2:0] FCM_OP_CHIP = 3'h3;
  localparam logic [2:0] FCM_OP_SECURE = 3'h4;
  // Busy time of the flash array model, in cycles.
  localparam int FCM_BUSY_CYCLES = 400;
  localparam logic [1:0] FCM_RESP_OKAY = 2'h0;
  localparam logic [1:0] FCM_RESP_SLVERR = 2'h2;
endpackage : fcm_pkg

/* hdl/fcm_seq.sv */
// Command sequence decoder with toggle bit generation.
`timescale 1ns/10ps
`default_nettype none
module fcm_seq
  import fcm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic cmd_en_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] data_i,
  input wire logic rd_i,
  output logic [2:0] op_o,
  output logic op_stb_o,
  output logic [15:0] op_addr_o,
  output logic [7:0] op_data_o,
  output logic id_mode_o,
  output logic busy_o,
  output logic toggle_o
);
  typedef enum {S_IDLE, S_C1, S_C2, S_PROG, S_C3E, S_C4E, S_C5E, S_SEC} fcm_seq_t;
  fcm_seq_t st_r;
  fcm_seq_t st_nxt;
  logic [15:0] busy_cnt_r;
  logic toggle_r;
  logic id_r;
  logic [2:0] op_r;
  logic stb_r;
  logic [15:0] oa_r;
  logic [7:0] od_r;
  // Upper nibble 8 to F accepted in command addresses.
  wire hi_ok = addr_i[15];
  wire at555 = hi_ok && addr_i[11:0] == FCM_ADDR_555;
  wire ataaa = hi_ok && addr_i[11:0] == FCM_ADDR_AAA;
  // A write is taken only while decoding is enabled and the array is idle.
  wire take = wr_i && cmd_en_i && busy_cnt_r == 16'h0000;
  logic [2:0] op_nxt;

  // Next state of the sequence and the operation launched.
  always_comb begin
    st_nxt = st_r;
    op_nxt = FCM_OP_NONE;
    if (take) begin
      st_nxt = S_IDLE;
      unique case (st_r)
        S_IDLE: if (at555 && data_i == FCM_CMD_UNLOCK1) st_nxt = S_C1;
        S_C1: if (ataaa && data_i == FCM_CMD_UNLOCK2) st_nxt = S_C2;
        S_C2: begin
          if (at555 && data_i == FCM_CMD_PROG) st_nxt = S_PROG;
          else if (at555 && data_i == FCM_CMD_ERASE) st_nxt = S_C3E;
          else if (at555 && data_i == FCM_CMD_SECURE) st_nxt = S_SEC;
        end
        S_PROG: if (hi_ok) op_nxt = FCM_OP_PROG;
        S_C3E: if (at555 && data_i == FCM_CMD_UNLOCK1) st_nxt = S_C4E;
        S_C4E: if (ataaa && data_i == FCM_CMD_UNLOCK2) st_nxt = S_C5E;
        S_C5E: begin
          if (hi_ok && data_i == FCM_CMD_SECTOR) op_nxt = FCM_OP_SECTOR;
          else if (at555 && data_i == FCM_CMD_CHIP) op_nxt = FCM_OP_CHIP;
        end
        S_SEC: begin
          if (addr_i == FCM_SECURE_ADDR && data_i == FCM_SECURE_DATA) op_nxt = FCM_OP_SECURE;
        end
      endcase
    end
  end

  // Sequence state, ID mode, launched operation and the busy counter.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_r <= S_IDLE;
      id_r <= 1'b0;
      op_r <= FCM_OP_NONE;
      stb_r <= 1'b0;
      oa_r <= 16'h0000;
      od_r <= 8'h00;
      busy_cnt_r <= 16'h0000;
      toggle_r <= 1'b1;
    end else if (ce_i) begin
      st_r <= st_nxt;
      stb_r <= op_nxt != FCM_OP_NONE;
      if (take && st_r == S_C2 && at555 && data_i == FCM_CMD_ID) id_r <= 1'b1;
      else if (take && data_i == FCM_CMD_ID_EXIT) id_r <= 1'b0;
      if (op_nxt != FCM_OP_NONE) begin
        op_r <= op_nxt;
        oa_r <= addr_i;
        od_r <= data_i;
        busy_cnt_r <= 16'(FCM_BUSY_CYCLES);
        toggle_r <= 1'b1; // First read after launch shows one.
      end else if (busy_cnt_r != 16'h0000) begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
        if (rd_i && cmd_en_i) toggle_r <= ~toggle_r;
      end
    end
  end
  assign op_o = op_r;
  assign op_stb_o = stb_r;
  assign op_addr_o = oa_r;
  assign op_data_o = od_r;
  assign id_mode_o = id_r;
  assign busy_o = busy_cnt_r != 16'h0000;
  assign toggle_o = toggle_r;

  // Launch happens exactly one cycle after the final enabled write.
  property p_launch;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && op_nxt != FCM_OP_NONE) |=> (op_stb_o && busy_o);
  endproperty
  a_launch: assert property (p_launch) else $error("Launch not seen");
  // No launch while decoding is disabled.
  property p_no_cmd;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && !cmd_en_i) |=> !op_stb_o;
  endproperty
  a_no_cmd: assert property (p_no_cmd) else $error("Command taken while disabled");
  // Sector erase follows the sixth write with 30.
  sequence s_sec6;
    take && st_r == S_C5E && hi_ok && data_i == FCM_CMD_SECTOR && ce_i;
  endsequence
  property p_sector;
    @(posedge clk_i) disable iff (!rst_b_i) s_sec6 |=> op_o == FCM_OP_SECTOR;
  endproperty
  a_sector: assert property (p_sector) else $error("Sector erase missed");
endmodule : fcm_seq
`default_nettype wire

/* hdl/fcm_sync.sv */
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module fcm_sync (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic q_r;
  // Shift the pin in; the output follows once stages two and three agree.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_r <= 1'b0;
    end else if (ce_i) begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) q_r <= s3_r;
    end
  end
  assign q_o = q_r;
endmodule : fcm_sync
`default_nettype wire

/* hdl/fcm_top.sv */
// Flash command and memory map control with an AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module fcm_top
  import fcm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // AXI4-Lite slave.
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CPU memory bus.
  input wire logic serial_prom_mode_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_code_i,
  input wire logic cpu_fetch_from_ram_i,
  input wire logic [15:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic irq_ack_i,
  input wire logic [7:0] flash_rdata_i,
  output logic [7:0] cpu_rdata_o,
  output logic sel_flash_o,
  output logic sel_boot_rom_o,
  output logic sel_ram_code_o,
  output logic [15:0] flash_phys_addr_o,
  output logic flash_access_o,
  output logic standby_reset_o,
  output logic [2:0] op_o,
  output logic op_stb_o,
  output logic [15:0] op_addr_o,
  output logic [7:0] op_data_o,
  output logic id_mode_o,
  output logic flash_busy_o,
  // Port input gating.
  input wire logic serial_clock_pin_i,
  input wire logic [7:0] other_port_pins_i,
  output logic serial_clock_pin_o,
  output logic [7:0] other_port_pins_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] map_stage_r;
  logic [7:0] map_active_r;
  logic standby_r;
  logic [1:0] port_ctrl_r;
  logic [1:0] sys_cfg3_r;
  logic [1:0] sys_active_r;
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic [7:0] cpu_rdata_r;
  logic sclk_sync;
  logic [7:0] other_sync;
  logic toggle;
  logic w_s0_r;

  // Write channel handshake: address and data taken in either order.
  assign s_axi_awready = !aw_got_r && !bvalid_r;
  assign s_axi_wready = !w_got_r && !bvalid_r;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire aw_have = aw_got_r || aw_hs;
  wire w_have = w_got_r || w_hs;
  wire [7:0] wa = aw_got_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wd = w_got_r ? w_data_r : s_axi_wdata;
  wire ws0 = w_got_r ? w_s0_r : s_axi_wstrb[0];
  wire wr_do = aw_have && w_have && !bvalid_r && ws0;
  wire wr_any = aw_have && w_have && !bvalid_r;
  wire wa_ok = wa == FCM_OFS_MAP_CTRL || wa == FCM_OFS_COMMIT || wa == FCM_OFS_MONITOR
    || wa == FCM_OFS_STANDBY || wa == FCM_OFS_PORT_CTRL || wa == FCM_OFS_SYS_CFG3
    || wa == FCM_OFS_SYS_KEY || wa == FCM_OFS_STATUS;
  wire wr_map = wr_do && wa == FCM_OFS_MAP_CTRL;
  wire [7:0] stage_wr = serial_prom_mode_i ? {wd[7:5], map_stage_r[4], wd[3:0]}
    : wd[7:0];
  wire commit = wr_do && wa == FCM_OFS_COMMIT && wd[7:0] == FCM_COMMIT_KEY;
  wire sys_commit = wr_do && wa == FCM_OFS_SYS_KEY && wd[7:0] == FCM_SYS_KEY;
  // Standby bit accepted only while the CPU runs from RAM.
  wire wr_stb = wr_do && wa == FCM_OFS_STANDBY && cpu_fetch_from_ram_i;
  wire wr_port = wr_do && wa == FCM_OFS_PORT_CTRL && serial_prom_mode_i;

  // Active fields decoded from the committed shadow.
  wire [2:0] mode_act = map_active_r[FCM_POS_MODE +: 3];
  wire [1:0] win_act = map_active_r[FCM_POS_WIN +: 2];
  wire cmd_en = mode_act == FCM_MODE_ENABLE;
  wire boot_act = serial_prom_mode_i || map_active_r[FCM_POS_BOOT];
  wire ram_map = serial_prom_mode_i || sys_active_r[0];
  wire vec_ram = sys_active_r[1];
  wire [7:0] monitor = {2'b00, cmd_en, boot_act, win_act, map_active_r[1:0]};

  // Read mux of the register file.
  wire ra_ok = s_axi_araddr == FCM_OFS_MAP_CTRL || s_axi_araddr == FCM_OFS_COMMIT
    || s_axi_araddr == FCM_OFS_MONITOR || s_axi_araddr == FCM_OFS_STANDBY
    || s_axi_araddr == FCM_OFS_PORT_CTRL || s_axi_araddr == FCM_OFS_SYS_CFG3
    || s_axi_araddr == FCM_OFS_SYS_KEY || s_axi_araddr == FCM_OFS_STATUS;
  wire [7:0] stage_rd = serial_prom_mode_i ? (map_stage_r | 8'h10) : map_stage_r;
  wire [7:0] port_rd = serial_prom_mode_i ? {6'h20, port_ctrl_r} : 8'h00;
  wire [7:0] rd_mux =
    s_axi_araddr == FCM_OFS_MAP_CTRL ? stage_rd :
    s_axi_araddr == FCM_OFS_MONITOR ? monitor :
    s_axi_araddr == FCM_OFS_PORT_CTRL ? port_rd :
    s_axi_araddr == FCM_OFS_SYS_CFG3 ? {6'h00, sys_cfg3_r} :
    s_axi_araddr == FCM_OFS_STATUS ? {4'h0, id_mode_o, flash_busy_o, standby_r, ram_map} :
    8'h00;
  assign s_axi_arready = !rvalid_r;
  wire ar_hs = s_axi_arvalid && s_axi_arready;

  ////////////////////////////////////////////////////////////////////////////
  // Flash address map.
  wire in_upper = cpu_addr_i[15];
  wire in_boot_d = cpu_addr_i >= FCM_BOOT_LO && cpu_addr_i <= FCM_BOOT_HI_DATA;
  wire in_boot_c = cpu_addr_i >= FCM_BOOT_LO
    && cpu_addr_i <= (serial_prom_mode_i ? FCM_BOOT_HI_CODE : FCM_BOOT_HI_DATA);
  wire boot_hit = boot_act && (cpu_code_i ? in_boot_c : in_boot_d);
  wire code_to_ram = cpu_code_i && ram_map && cpu_fetch_from_ram_i;
  wire flash_hit = (cpu_rd_i || cpu_wr_i) && !boot_hit && !code_to_ram && in_upper;
  // Code window remap: data upper half reaches the same cells the code space uses.
  wire code_win = win_act == FCM_WIN_CODE;
  // Writes reach the flash only as data-space transfers.
  wire data_wr = cpu_wr_i && !cpu_code_i && flash_hit;
  assign sel_flash_o = flash_hit;
  assign sel_boot_rom_o = boot_hit;
  assign sel_ram_code_o = code_to_ram;
  assign flash_phys_addr_o = {code_win | cpu_code_i, cpu_addr_i[14:0]};
  assign flash_access_o = flash_hit;
  // A flash access during standby asserts the standby reset request, except during an interrupt acknowledge whose vector is in flash.
  wire fetch_vec_flash = irq_ack_i && !vec_ram;
  assign standby_reset_o = standby_r && flash_hit && !fetch_vec_flash;

  fcm_seq u_seq (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .cmd_en_i(cmd_en),
    .wr_i(data_wr),
    .addr_i(cpu_addr_i),
    .data_i(cpu_wdata_i),
    .rd_i(cpu_rd_i && flash_hit),
    .op_o(op_o),
    .op_stb_o(op_stb_o),
    .op_addr_o(op_addr_o),
    .op_data_o(op_data_o),
    .id_mode_o(id_mode_o),
    .busy_o(flash_busy_o),
    .toggle_o(toggle)
  );

  // CPU read data with toggle bit substituted while busy.
  wire [7:0] cpu_rd_nxt = (flash_busy_o && cmd_en) ?
    {flash_rdata_i[7], toggle, flash_rdata_i[5:0]} : flash_rdata_i;
  assign cpu_rdata_o = cpu_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and gating.
  fcm_sync u_sclk (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .d_i(serial_clock_pin_i),
    .q_o(sclk_sync)
  );
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      fcm_sync u_pin (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .ce_i(ce_i),
        .d_i(other_port_pins_i[gi]),
        .q_o(other_sync[gi])
      );
    end
  endgenerate
  // Serial PROM mode gates inputs by the control bits; MCU mode passes all.
  wire sclk_en = !serial_prom_mode_i || port_ctrl_r[1];
  wire other_en = !serial_prom_mode_i || port_ctrl_r[0];

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      map_stage_r <= FCM_MAP_RESET;
      map_active_r <= FCM_MAP_RESET;
      sys_cfg3_r <= 2'b00;
      sys_active_r <= 2'b00;
      port_ctrl_r <= 2'b00;
      standby_r <= 1'b0;
      cpu_rdata_r <= 8'h00;
      serial_clock_pin_o <= 1'b0;
      other_port_pins_o <= 8'h00;
    end else if (ce_i) begin
      if (wr_map) map_stage_r <= stage_wr;
      if (commit) map_active_r <= map_stage_r;
      if (wr_do && wa == FCM_OFS_SYS_CFG3) sys_cfg3_r <= wd[1:0];
      if (sys_commit) sys_active_r <= sys_cfg3_r;
      if (wr_port) port_ctrl_r <= wd[1:0];
      // Interrupt with flash vector clears standby; a RAM write in the same cycle still loads it.
      if (wr_stb) standby_r <= wd[0];
      else if (fetch_vec_flash) standby_r <= 1'b0;
      cpu_rdata_r <= cpu_rd_nxt;
      serial_clock_pin_o <= sclk_en & sclk_sync;
      other_port_pins_o <= other_en ? other_sync : 8'h00;
    end
  end

  // AXI channel state.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_s0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= FCM_RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= FCM_RESP_OKAY;
    end else if (ce_i) begin
      if (wr_any) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wa_ok ? FCM_RESP_OKAY : FCM_RESP_SLVERR;
      end else begin
        if (aw_hs) aw_got_r <= 1'b1;
        if (w_hs) w_got_r <= 1'b1;
        if (bvalid_r && s_axi_bready) bvalid_r <= 1'b0;
      end
      if (aw_hs) aw_addr_r <= s_axi_awaddr;
      if (w_hs) w_data_r <= s_axi_wdata;
      if (w_hs) w_s0_r <= s_axi_wstrb[0];
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r <= {24'h00_0000, rd_mux};
        rresp_r <= ra_ok ? FCM_RESP_OKAY : FCM_RESP_SLVERR;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  ////////////////////////////////////////////////////////////////////////////
  // Staged value reaches the shadow only on the commit key.
  property p_commit;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && !commit) |=> $stable(map_active_r);
  endproperty
  a_commit: assert property (p_commit) else $error("Shadow changed without commit");
  property p_enable;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && commit && map_stage_r[FCM_POS_MODE +: 3] == FCM_MODE_ENABLE) |=> cmd_en;
  endproperty
  a_enable: assert property (p_enable) else $error("Enable not applied");
  property p_standby;
    @(posedge clk_i) disable iff (!rst_b_i)
      (standby_r && sel_flash_o && !irq_ack_i) |-> standby_reset_o;
  endproperty
  a_standby: assert property (p_standby) else $error("Standby reset missing");
  property p_irq_clr;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && fetch_vec_flash && !wr_stb) |=> !standby_r;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("Standby not cleared");
  property p_flash_wr;
    @(posedge clk_i) disable iff (!rst_b_i)
      (ce_i && !cpu_fetch_from_ram_i) |=> $stable(standby_r) || $past(fetch_vec_flash);
  endproperty
  a_flash_wr: assert property (p_flash_wr) else $error("Standby written from flash");
endmodule : fcm_top
`default_nettype wire

/* testbench/fcm_cpu_bfm.sv */
// CPU core model that issues flash-space bus writes and reads.
`timescale 1ns/10ps
`default_nettype none
module fcm_cpu_bfm (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o
);
  // Idle bus at time zero.
  initial begin
    wr_o = 1'h0;
    rd_o = 1'h0;
    addr_o = 16'h0000;
    wdata_o = 8'h00;
  end
  // One access a call, always in the data space; the bench also calls it while standby is set.
  // Released write data shows the inverse so a stale value cannot pass for a new one.
  task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_o <= w;
    rd_o <= ~w;
    addr_o <= a;
    wdata_o <= d;
    @(posedge clk_i);
    wr_o <= 1'h0;
    rd_o <= 1'h0;
    wdata_o <= ~d;
  endtask : acc
endmodule : fcm_cpu_bfm
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the flash command and map control block.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import fcm_pkg::*;
  typedef struct packed {logic [3:0] hi; logic [7:0] c3, d_end; logic [15:0] a_end;
    logic [2:0] op;} fcm_row_t;
  logic clk_i = 1'h0, rst_b_i = 1'h0, serial_prom_mode_i = 1'h0, cpu_fetch_from_ram_i = 1'h0;
  logic irq_ack_i = 1'h0, serial_clock_pin_i = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, sr_seen = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, other_port_pins_i = 8'hFF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_q;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp_q;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic cpu_wr_i, cpu_rd_i, standby_reset_o, op_stb_o, id_mode_o, flash_busy_o, serial_clock_pin_o;
  logic [15:0] cpu_addr_i, op_addr_o;
  logic [7:0] cpu_wdata_i, cpu_rdata_o, other_port_pins_o, op_data_o;
  logic cpu_code_i = 1'h0, sel_ram_code_o, sel_boot_rom_o;
  logic [2:0] op_o, last_op = 3'h0;
  int fail_count = 0, check_count = 0, cyc = 0;
  fcm_row_t rows [5] = '{'{4'h8, FCM_CMD_PROG, 8'h5A, 16'h9123, FCM_OP_PROG},
    '{4'hF, FCM_CMD_ERASE, FCM_CMD_SECTOR, 16'hB7FF, FCM_OP_SECTOR},
    '{4'hA, FCM_CMD_ERASE, FCM_CMD_CHIP, 16'hA555, FCM_OP_CHIP},
    '{4'hF, FCM_CMD_SECURE, FCM_SECURE_DATA, FCM_SECURE_ADDR, FCM_OP_SECURE},
    '{4'hC, FCM_CMD_ID, 8'h00, 16'h0000, FCM_OP_NONE}};

  fcm_top DUT (.clk_i, .rst_b_i, .ce_i(1'h1), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .serial_prom_mode_i, .cpu_wr_i, .cpu_rd_i, .cpu_code_i,
    .cpu_fetch_from_ram_i, .cpu_addr_i, .cpu_wdata_i, .irq_ack_i, .flash_rdata_i(8'h25),
    .cpu_rdata_o, .sel_flash_o(), .sel_boot_rom_o, .sel_ram_code_o, .flash_phys_addr_o(),
    .flash_access_o(), .standby_reset_o, .op_o, .op_stb_o, .op_addr_o, .op_data_o,
    .id_mode_o, .flash_busy_o, .serial_clock_pin_i, .other_port_pins_i, .serial_clock_pin_o,
    .other_port_pins_o);
  fcm_cpu_bfm cpu (.clk_i, .wr_o(cpu_wr_i), .rd_o(cpu_rd_i), .addr_o(cpu_addr_i),
    .wdata_o(cpu_wdata_i));

  // Clock, then strobe capture, standby-reset watch and the cycle ceiling.
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (op_stb_o === 1'h1) last_op <= op_o;
    if (cpu_rd_i === 1'h1 && standby_reset_o === 1'h1) sr_seen <= 1'h1;
    if (cyc == 6000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  // One register write (w high) or read; each channel is held until its ready.
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= ~w;
    s_axi_rready <= ~w;
    @(posedge clk_i);
    while (!(w ? s_axi_awready && s_axi_wready : s_axi_arready)) @(posedge clk_i);
    s_axi_awvalid <= 1'h0;
    s_axi_wvalid <= 1'h0;
    s_axi_arvalid <= 1'h0;
    @(posedge clk_i);
    while (!(w ? s_axi_bvalid : s_axi_rvalid)) @(posedge clk_i);
    rd_q = s_axi_rdata;
    resp_q = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
  endtask : ax
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    ax(1'h0, a, 32'h0);
    chk(rd_q, e);
  endtask : rchk
  // Sends one command row: unlock pair, command byte, second pair for erases, last write except for the ID command.
  task automatic seq(input fcm_row_t r);
    cpu.acc(1'h1, {r.hi, FCM_ADDR_555}, FCM_CMD_UNLOCK1);
    cpu.acc(1'h1, {r.hi, FCM_ADDR_AAA}, FCM_CMD_UNLOCK2);
    cpu.acc(1'h1, {r.hi, FCM_ADDR_555}, r.c3);
    if (r.c3 == FCM_CMD_ERASE) begin
      cpu.acc(1'h1, {r.hi, FCM_ADDR_555}, FCM_CMD_UNLOCK1);
      cpu.acc(1'h1, {r.hi, FCM_ADDR_AAA}, FCM_CMD_UNLOCK2);
    end
    if (r.c3 != FCM_CMD_ID) cpu.acc(1'h1, r.a_end, r.d_end);
    repeat (3) @(posedge clk_i);
  endtask : seq
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  // Reset, the command table, then the map, standby and port input cases.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'h1;
    rchk(FCM_OFS_MONITOR, 32'h0);
    rchk(8'h20, 32'h0);
    chk(resp_q, FCM_RESP_SLVERR);
    seq(rows[0]);
    chk({flash_busy_o, last_op}, 4'h0);
    ax(1'h1, FCM_OFS_MAP_CTRL, {FCM_MODE_ENABLE, 5'h00});
    rchk(FCM_OFS_MONITOR, 32'h0);
    ax(1'h1, FCM_OFS_COMMIT, FCM_COMMIT_KEY);
    rchk(FCM_OFS_MONITOR, 32'h20);
    foreach (rows[i]) begin
      last_op = FCM_OP_NONE;
      seq(rows[i]);
      chk({last_op, id_mode_o}, {rows[i].op, rows[i].c3 == FCM_CMD_ID});
      if (rows[i].op != FCM_OP_NONE) begin
        chk({op_addr_o, op_data_o}, {rows[i].a_end, rows[i].d_end});
        for (int k = 0; k < 2; k++) begin
          cpu.acc(1'h0, 16'h9000, 8'h00);
          @(negedge clk_i);
          chk({flash_busy_o, cpu_rdata_o}, k ? 9'h125 : 9'h165);
        end
        while (flash_busy_o) @(posedge clk_i);
      end
    end
    cpu.acc(1'h1, 16'hF000, FCM_CMD_ID_EXIT);
    @(negedge clk_i);
    chk(id_mode_o, 1'h0);
    ax(1'h1, FCM_OFS_MAP_CTRL, {FCM_MODE_ENABLE, 1'h1, FCM_WIN_CODE, 2'h0});
    ax(1'h1, FCM_OFS_COMMIT, FCM_COMMIT_KEY);
    rchk(FCM_OFS_MONITOR, 32'h38);
    cpu.acc(1'h0, 16'h1000, 8'h00);
    chk(sel_boot_rom_o, 1'h1);
    ax(1'h1, FCM_OFS_MAP_CTRL, {FCM_MODE_DISABLE, 1'h0, FCM_WIN_DEFAULT, 2'h0});
    ax(1'h1, FCM_OFS_COMMIT, FCM_COMMIT_KEY);
    rchk(FCM_OFS_MONITOR, 32'h0);
    seq(rows[0]);
    chk({flash_busy_o, last_op}, 4'h0);
    ax(1'h1, FCM_OFS_SYS_CFG3, 32'h1);
    rchk(FCM_OFS_STATUS, 32'h0);
    ax(1'h1, FCM_OFS_SYS_KEY, FCM_SYS_KEY);
    rchk(FCM_OFS_STATUS, 32'h1);
    ax(1'h1, FCM_OFS_STANDBY, 32'h1);
    rchk(FCM_OFS_STATUS, 32'h1);
    cpu_fetch_from_ram_i <= 1'h1;
    ax(1'h1, FCM_OFS_STANDBY, 32'h1);
    rchk(FCM_OFS_STATUS, 32'h3);
    cpu_code_i <= 1'h1;
    @(negedge clk_i);
    chk(sel_ram_code_o, 1'h1);
    @(posedge clk_i);
    cpu_code_i <= 1'h0;
    cpu_fetch_from_ram_i <= 1'h0;
    cpu.acc(1'h0, 16'h9000, 8'h00);
    @(negedge clk_i);
    chk(sr_seen, 1'h1);
    @(posedge clk_i);
    irq_ack_i <= 1'h1;
    @(posedge clk_i);
    irq_ack_i <= 1'h0;
    rchk(FCM_OFS_STATUS, 32'h1);
    serial_prom_mode_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    chk({serial_clock_pin_o, other_port_pins_o}, 9'h0);
    rchk(FCM_OFS_MONITOR, 32'h10);
    ax(1'h1, FCM_OFS_PORT_CTRL, 32'h2);
    repeat (8) @(posedge clk_i);
    chk({serial_clock_pin_o, other_port_pins_o}, 9'h100);
    ax(1'h1, FCM_OFS_PORT_CTRL, 32'h1);
    rchk(FCM_OFS_PORT_CTRL, 32'h81);
    chk({serial_clock_pin_o, other_port_pins_o}, 9'h0FF);
    serial_prom_mode_i <= 1'h0;
    ax(1'h1, FCM_OFS_PORT_CTRL, 32'h0);
    repeat (8) @(posedge clk_i);
    chk({serial_clock_pin_o, other_port_pins_o}, 9'h1FF);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
